//--- rtl/bcd_decoder.sv
// Purpose: Block command decoder of the detector interface board
// Assumes: Commands arrive one per cycle, already deframed and checked
// Notes: Long operations are done outside; this block issues and tracks them
// Overview of operation
// - Code 0x000C loads the configuration set selected by data into a slab.
// - Code 0x000C with data 0x0080 reads back all stored sets instead.
// - Code 0x000E forwards slab results; busy until the transfer is done.
// - Code 0x0012 returns control, status one or status two for data 1 to 3.
// - Code 0x0014 returns board information picked by one-hot data; 0x0040 all.
// - Code 0x0018 accepts firmware words while staying idle.
// - Code 0x001A picks command source; 0x0002 resets input selection.
// - Code 0x0070 sensor fetch 1/3 and send 2/4 operations.
// - Code 0x0072 with 0x1000 returns calibration status, state unchanged.
// - Code 0x0074 loads calibration settings; 0x0076 data 1 reads them.
// - Code 0x0078 data 1 reads probe registers; busy until complete.
// - Codes 0x0030-0x008F are reserved for detector variants.
// - While busy, commands other than reset or emergency are ignored.
// - After a busy operation completes, return to idle and accept commands.
// - Supply data 1 turns slab supply on, 0 turns off, in bit 0.
// - Supply bit 1 gives automatic power control, only with bit 0 set.
// - Clearing the supply bit clears the automatic bit.
// - Bunch-counter clear comes from fast command; bit 4 high for 4 cycles.
// - Reset data 0x0008 clears front-end configuration for 6 cycles.
// - Reset data 0x0004 resets board and slabs for 6 cycles.
// - Reset data 0x0002 resets slab electronics for 6 cycles.
// - Reset data 0x0001 resets board logic for 6 cycles.
`timescale 1ns/1ps
module bcd_decoder (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire bcd_pkg::bcd_cmd_t cmd,
    input wire logic fast_bunch_clear,
    input wire logic emergency,
    input wire logic op_done,
    input wire logic [15:0] status1,
    input wire logic [15:0] status2,
    input wire logic [15:0] cal_status,
    input wire logic [15:0] info_word,
    output bcd_pkg::bcd_reply_t reply,
    output bcd_pkg::bcd_op_t op,
    output logic [15:0] op_data,
    output logic op_valid,
    output logic busy,
    output logic [15:0] supply_reg,
    output logic [15:0] reset_reg,
    output logic [15:0] control_reg,
    output logic [1:0] input_sel,
    output logic input_sel_clear,
    output logic slab_power,
    output logic auto_power,
    output logic bunch_counter_clear,
    output logic asic_config_clear,
    output logic board_logic_clear,
    output logic slab_clear
);
    logic [15:0] supply_r;
    logic [15:0] control_r;
    logic [1:0] sel_r;
    logic sel_clr_r;
    bcd_pkg::bcd_reply_t reply_r;
    bcd_pkg::bcd_op_t op_r;
    logic [15:0] op_data_r;
    logic op_valid_r;
    logic busy_w;
    logic p_board;
    logic p_slab;
    logic p_all;
    logic p_cfg;
    logic p_bunch;
    logic [15:0] reset_w;
    logic [15:0] reset_q_r;
    logic out_board_r;
    logic out_slab_r;
    logic out_cfg_r;
    logic out_bunch_r;

    // Decode of the incoming command
    wire is_rb = cmd.data == bcd_pkg::D_READBACK;
    wire c_sup = cmd.code == bcd_pkg::CMD_SUPPLY;
    wire c_rst = cmd.code == bcd_pkg::CMD_RESET;
    wire c_load = cmd.code == bcd_pkg::CMD_LOAD_SET;
    wire c_res = cmd.code == bcd_pkg::CMD_RESULTS;
    wire c_ctl = cmd.code == bcd_pkg::CMD_SET_CTRL;
    wire c_stat = cmd.code == bcd_pkg::CMD_READ_STAT;
    wire c_info = cmd.code == bcd_pkg::CMD_INFO;
    wire c_fw = cmd.code == bcd_pkg::CMD_FW_LOAD;
    wire c_sel = cmd.code == bcd_pkg::CMD_SEL_INPUT;
    wire c_sens = cmd.code == bcd_pkg::CMD_SENSOR;
    wire c_cals = cmd.code == bcd_pkg::CMD_CAL_STAT;
    wire c_call = cmd.code == bcd_pkg::CMD_CAL_LOAD;
    wire c_calr = cmd.code == bcd_pkg::CMD_CAL_READ;
    wire c_prb = cmd.code == bcd_pkg::CMD_PROBE;
    // Variant ranges not otherwise decoded here
    wire c_var = ((cmd.code >= bcd_pkg::VAR_A_LO) && (cmd.code <= bcd_pkg::VAR_C_HI))
        && !c_sens && !c_cals && !c_call && !c_calr && !c_prb;

    // Busy gate: only reset commands and emergencies get through while busy
    wire acc = cmd.valid && (!busy_w || c_rst);
    wire acc_rw = acc && !is_rb;

    // Starts of operations that leave idle
    wire st_load = acc_rw && c_load;
    wire st_res = acc_rw && c_res;
    wire st_sens = acc_rw && c_sens && (cmd.data >= bcd_pkg::D_ONE)
        && (cmd.data <= bcd_pkg::D_FOUR);
    wire st_prb = acc_rw && c_prb && (cmd.data == bcd_pkg::D_ONE);
    wire start = st_load || st_res || st_sens || st_prb;

    // Reset command triggers
    wire rst_wr = acc_rw && c_rst;
    wire t_board = rst_wr && (cmd.data == bcd_pkg::D_ONE);
    wire t_slab = rst_wr && (cmd.data == bcd_pkg::D_TWO);
    wire t_all = rst_wr && (cmd.data == bcd_pkg::D_FOUR);
    wire t_cfg = rst_wr && (cmd.data == bcd_pkg::D_EIGHT);

    // Supply register next value; clearing power drops automatic
    wire sup_on = acc_rw && c_sup && (cmd.data == bcd_pkg::D_ONE);
    wire sup_off = acc_rw && c_sup && (cmd.data == bcd_pkg::D_ZERO);
    wire sup_auto = acc_rw && c_sup && (cmd.data == bcd_pkg::D_TWO);
    wire [15:0] sup_nxt = sup_off ? 16'h0000 :
        sup_on ? (supply_r | 16'h0001) :
        (sup_auto && supply_r[bcd_pkg::SUP_POWER_BIT]) ? (supply_r | 16'h0002) :
        supply_r;

    // Reset register view: bit 4 read-only from the fast path
    assign reset_w = {11'h000, p_bunch, p_cfg, p_all, p_slab, p_board};

    // Readback value selection
    wire [15:0] stat_sel = (cmd.data == bcd_pkg::D_ONE) ? control_r :
        (cmd.data == bcd_pkg::D_TWO) ? status1 :
        (cmd.data == bcd_pkg::D_THREE) ? status2 : 16'h0000;
    wire stat_ok = (cmd.data >= bcd_pkg::D_ONE) && (cmd.data <= bcd_pkg::D_THREE);
    wire info_ok = (cmd.data != 16'h0000) && ((cmd.data & (cmd.data - 16'h0001)) == 16'h0000)
        && (cmd.data <= bcd_pkg::D_INFO_ALL);
    wire rb_sup = acc && c_sup && is_rb;
    wire rb_rst = acc && c_rst && is_rb;
    wire rb_sel = acc && c_sel && is_rb;
    wire rb_cal = acc && c_cals && is_rb;
    wire rb_stat = acc && c_stat && stat_ok;
    wire rb_info = acc && c_info && info_ok;
    wire reply_v = rb_sup || rb_rst || rb_sel || rb_cal || rb_stat || rb_info;
    wire [15:0] reply_d = rb_sup ? supply_r :
        rb_rst ? reset_w :
        rb_sel ? {14'h0000, sel_r} :
        rb_cal ? cal_status :
        rb_stat ? stat_sel : info_word;

    // Operation request selection for the surrounding logic
    wire fw_word = acc_rw && c_fw;
    wire cal_ld = acc_rw && c_call;
    wire cal_rd = acc && c_calr && (cmd.data == bcd_pkg::D_ONE);
    wire var_op = acc && c_var;
    wire rd_sets = st_load && (cmd.data == bcd_pkg::D_READ_ALL_SETS);
    bcd_pkg::bcd_op_t op_nxt;
    assign op_nxt = rd_sets ? bcd_pkg::BCD_OP_READ_SETS :
        st_load ? bcd_pkg::BCD_OP_LOAD_SET :
        st_res ? bcd_pkg::BCD_OP_RESULTS :
        st_sens ? bcd_pkg::BCD_OP_SENSOR :
        st_prb ? bcd_pkg::BCD_OP_PROBE :
        fw_word ? bcd_pkg::BCD_OP_FW_WORD :
        cal_ld ? bcd_pkg::BCD_OP_CAL_LOAD :
        cal_rd ? bcd_pkg::BCD_OP_CAL_READ :
        rb_info ? bcd_pkg::BCD_OP_INFO :
        var_op ? bcd_pkg::BCD_OP_VARIANT : bcd_pkg::BCD_OP_NONE;
    wire op_v = op_nxt != bcd_pkg::BCD_OP_NONE;

    // Source selection; data 2 pulses the selection-logic clear
    wire sel_wr = acc_rw && c_sel && (cmd.data <= bcd_pkg::D_ONE);
    wire sel_clr = acc_rw && c_sel && (cmd.data == bcd_pkg::D_TWO);

    // Busy tracker; emergency or a board or general reset aborts the operation
    bcd_busy u_busy (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .start(start),
        .done(op_done),
        .abort(emergency || t_all || t_board),
        .busy(busy_w)
    );

    // Reset pulse stretchers, one per reset line
    bcd_pulse #(.LEN(bcd_pkg::PULSE_CYCLES)) u_p_board (
        .ref_clk(ref_clk), .resetn(resetn), .trig(t_board), .active(p_board));
    bcd_pulse #(.LEN(bcd_pkg::PULSE_CYCLES)) u_p_slab (
        .ref_clk(ref_clk), .resetn(resetn), .trig(t_slab), .active(p_slab));
    bcd_pulse #(.LEN(bcd_pkg::PULSE_CYCLES)) u_p_all (
        .ref_clk(ref_clk), .resetn(resetn), .trig(t_all), .active(p_all));
    bcd_pulse #(.LEN(bcd_pkg::PULSE_CYCLES)) u_p_cfg (
        .ref_clk(ref_clk), .resetn(resetn), .trig(t_cfg), .active(p_cfg));
    bcd_pulse #(.LEN(bcd_pkg::BUNCH_CYCLES)) u_p_bunch (
        .ref_clk(ref_clk), .resetn(resetn), .trig(fast_bunch_clear), .active(p_bunch));

    // Register file and source selection
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            supply_r <= bcd_pkg::SUPPLY_RESET;
            control_r <= bcd_pkg::CTRL_RESET;
            sel_r <= 2'h0;
            sel_clr_r <= 1'b0;
        end else begin
            supply_r <= sup_nxt;
            if (acc_rw && c_ctl) control_r <= cmd.data;
            if (sel_wr) sel_r <= cmd.data[1:0];
            else if (sel_clr) sel_r <= 2'h0;
            sel_clr_r <= sel_clr;
        end
    end

    // Reply and operation request registers, one cycle after the command
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reply_r <= '0;
            op_r <= bcd_pkg::BCD_OP_NONE;
            op_data_r <= 16'h0000;
            op_valid_r <= 1'b0;
        end else begin
            reply_r <= '{valid: reply_v, code: cmd.code, data: reply_d};
            op_r <= op_nxt;
            op_data_r <= cmd.data;
            op_valid_r <= op_v;
        end
    end

    // Output flops for the reset lines; general reset drives board and slab
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reset_q_r <= bcd_pkg::RESET_REG_RESET;
            out_board_r <= 1'b0;
            out_slab_r <= 1'b0;
            out_cfg_r <= 1'b0;
            out_bunch_r <= 1'b0;
        end else begin
            reset_q_r <= reset_w;
            out_board_r <= p_board || p_all;
            out_slab_r <= p_slab || p_all;
            out_cfg_r <= p_cfg;
            out_bunch_r <= p_bunch;
        end
    end

    assign reply = reply_r;
    assign op = op_r;
    assign op_data = op_data_r;
    assign op_valid = op_valid_r;
    assign busy = busy_w;
    assign supply_reg = supply_r;
    assign reset_reg = reset_q_r;
    assign control_reg = control_r;
    assign input_sel = sel_r;
    assign input_sel_clear = sel_clr_r;
    assign slab_power = supply_r[bcd_pkg::SUP_POWER_BIT];
    // Bit 1 only ever stands with bit 0, so the flop drives the pin directly
    assign auto_power = supply_r[bcd_pkg::SUP_AUTO_BIT];
    assign bunch_counter_clear = out_bunch_r;
    assign asic_config_clear = out_cfg_r;
    assign board_logic_clear = out_board_r;
    assign slab_clear = out_slab_r;

    // Automatic control never stands without slab supply
    a_auto_needs_pwr: assert property (@(posedge ref_clk) disable iff (!resetn)
        supply_r[bcd_pkg::SUP_AUTO_BIT] |-> supply_r[bcd_pkg::SUP_POWER_BIT])
        else $error("automatic set without supply");
    a_supply_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        sup_off |=> supply_r[1:0] == 2'b00)
        else $error("supply off did not clear bits");
    a_supply_on: assert property (@(posedge ref_clk) disable iff (!resetn)
        sup_on |=> supply_r[bcd_pkg::SUP_POWER_BIT])
        else $error("supply on not taken");
    a_cfg_pulse_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        t_cfg |=> p_cfg [*6] ##1 (!p_cfg || $past(t_cfg)))
        else $error("config clear length wrong");
    a_board_pulse_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        t_board |=> p_board [*6])
        else $error("board clear too short");
    a_slab_pulse_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        t_slab |=> p_slab [*6])
        else $error("slab clear too short");
    a_all_pulse_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        t_all |=> p_all [*6])
        else $error("general reset too short");
    a_bunch_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(p_bunch) && !fast_bunch_clear |-> p_bunch [*4] ##1 !p_bunch)
        else $error("bunch clear length wrong");
    a_busy_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy_w && cmd.valid && c_ctl |=> $stable(control_r))
        else $error("command taken while busy");
    a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!resetn)
        !busy_w && cmd.valid && c_ctl && !is_rb |=> control_r == $past(cmd.data))
        else $error("control write lost");
    a_busy_enter: assert property (@(posedge ref_clk) disable iff (!resetn)
        start && !emergency |=> busy_w)
        else $error("operation did not leave idle");
    a_busy_leave: assert property (@(posedge ref_clk) disable iff (!resetn)
        busy_w && op_done |=> !busy_w)
        else $error("no return to idle");
    a_readback_stable: assert property (@(posedge ref_clk) disable iff (!resetn)
        rb_sup |=> reply.valid && reply.data == $past(supply_r))
        else $error("supply readback wrong");
endmodule // bcd_decoder

//--- pkg/bcd_pkg.sv
// Purpose: Shared constants and types for the block command decoder
// Assumes: One 16-bit command code and one 16-bit data word per command
// Notes: Command codes double as register addresses for readback
package bcd_pkg;
    // Command codes
    localparam logic [15:0] CMD_SUPPLY = 16'h0002;
    localparam logic [15:0] CMD_RESET = 16'h0004;
    localparam logic [15:0] CMD_LOAD_SET = 16'h000C;
    localparam logic [15:0] CMD_RESULTS = 16'h000E;
    localparam logic [15:0] CMD_SET_CTRL = 16'h0010;
    localparam logic [15:0] CMD_READ_STAT = 16'h0012;
    localparam logic [15:0] CMD_INFO = 16'h0014;
    localparam logic [15:0] CMD_FW_LOAD = 16'h0018;
    localparam logic [15:0] CMD_SEL_INPUT = 16'h001A;
    localparam logic [15:0] CMD_SENSOR = 16'h0070;
    localparam logic [15:0] CMD_CAL_STAT = 16'h0072;
    localparam logic [15:0] CMD_CAL_LOAD = 16'h0074;
    localparam logic [15:0] CMD_CAL_READ = 16'h0076;
    localparam logic [15:0] CMD_PROBE = 16'h0078;
    // Variant ranges
    localparam logic [15:0] VAR_A_LO = 16'h0030;
    localparam logic [15:0] VAR_A_HI = 16'h004F;
    localparam logic [15:0] VAR_B_LO = 16'h0050;
    localparam logic [15:0] VAR_B_HI = 16'h006F;
    localparam logic [15:0] VAR_C_LO = 16'h0070;
    localparam logic [15:0] VAR_C_HI = 16'h008F;
    // Data words
    localparam logic [15:0] D_READBACK = 16'h1000;
    localparam logic [15:0] D_READ_ALL_SETS = 16'h0080;
    localparam logic [15:0] D_INFO_ALL = 16'h0040;
    localparam logic [15:0] D_ONE = 16'h0001;
    localparam logic [15:0] D_TWO = 16'h0002;
    localparam logic [15:0] D_THREE = 16'h0003;
    localparam logic [15:0] D_FOUR = 16'h0004;
    localparam logic [15:0] D_ZERO = 16'h0000;
    localparam logic [15:0] D_EIGHT = 16'h0008;
    // Register field positions and reset values
    localparam int SUP_POWER_BIT = 0;
    localparam int SUP_AUTO_BIT = 1;
    localparam int RST_BOARD_BIT = 0;
    localparam int RST_SLAB_BIT = 1;
    localparam int RST_ALL_BIT = 2;
    localparam int RST_CFG_BIT = 3;
    localparam int RST_BUNCH_BIT = 4;
    localparam logic [15:0] SUPPLY_RESET = 16'h0000;
    localparam logic [15:0] RESET_REG_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Pulse lengths in clock cycles and pulse counter width in bits
    localparam int PULSE_CYCLES = 6;
    localparam int BUNCH_CYCLES = 4;
    localparam int PCNT_W = 3;

    // Operation requests sent to the surrounding logic
    typedef enum logic [3:0] {
        BCD_OP_NONE, BCD_OP_LOAD_SET, BCD_OP_READ_SETS, BCD_OP_RESULTS,
        BCD_OP_FW_WORD, BCD_OP_SENSOR, BCD_OP_CAL_LOAD, BCD_OP_CAL_READ,
        BCD_OP_PROBE, BCD_OP_INFO, BCD_OP_VARIANT
    } bcd_op_t;

    // Incoming command
    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [15:0] data;
    } bcd_cmd_t;

    // Outgoing reply word
    typedef struct packed {
        logic valid;
        logic [15:0] code;
        logic [15:0] data;
    } bcd_reply_t;
endpackage

//--- rtl/bcd_pulse.sv
// Purpose: Fixed-length pulse stretcher for reset lines
// Assumes: Trigger is a one-cycle pulse
// Notes: A retrigger while active restarts the count
`timescale 1ns/1ps
module bcd_pulse #(
    parameter int LEN = 6
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic trig,
    output logic active
);
    logic [bcd_pkg::PCNT_W-1:0] cnt_r;

    // Count down from LEN, output high while nonzero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
        end else if (trig) begin
            cnt_r <= bcd_pkg::PCNT_W'(LEN);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign active = (cnt_r != '0);
endmodule // bcd_pulse

//--- rtl/bcd_busy.sv
// Purpose: Busy tracker for operations that leave idle
// Assumes: done arrives from the logic doing the work
// Notes: Abort covers emergency and the board and general reset commands
`timescale 1ns/1ps
module bcd_busy (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic done,
    input wire logic abort,
    output logic busy
);
    typedef enum logic {BCD_IDLE, BCD_BUSY} bcd_state_t;
    bcd_state_t state_r;
    bcd_state_t state_nxt;

    // Return to idle on completion or abort
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BCD_IDLE: if (start) state_nxt = BCD_BUSY;
            BCD_BUSY: if (done || abort) state_nxt = BCD_IDLE;
            default: state_nxt = BCD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= BCD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign busy = (state_r == BCD_BUSY);
endmodule // bcd_busy

//--- testbench/bcd_agg_model.sv
// Purpose: Aggregator-side model that issues block commands and completes operations
// Assumes: One command per valid pulse, changed just after a rising edge
// Notes: Completion comes DLY busy cycles after start; stall models a slow far side
`timescale 1ns/1ps
module bcd_agg_model #(
    parameter int DLY = 20
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic busy,
    input wire logic stall,
    output bcd_pkg::bcd_cmd_t cmd,
    output logic op_done
);
    logic [7:0] cnt_r;

    initial cmd = '0;

    // Held for one edge, then the word lines show the inverse so stale data never matches
    task automatic send(input logic [15:0] code, input logic [15:0] data);
        @(posedge ref_clk);
        cmd <= '{valid: 1'b1, code: code, data: data};
        @(posedge ref_clk);
        cmd <= '{valid: 1'b0, code: ~code, data: ~data};
    endtask

    // Completion pulse after a fixed busy span
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 8'h00;
            op_done <= 1'b0;
        end else begin
            cnt_r <= busy ? cnt_r + 8'h01 : 8'h00;
            op_done <= busy && !stall && (cnt_r == 8'(DLY - 1));
        end
    end
endmodule // bcd_agg_model

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the block command decoder
// Assumes: Commands are sent two cycles apart by the aggregator model
// Notes: Clear pulses are measured over a window, so latency is not pinned here
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic fast_bunch_clear = 1'b0;
    logic emergency = 1'b0;
    logic stall = 1'b0;
    logic [15:0] status1 = 16'h1357;
    logic [15:0] status2 = 16'h2468;
    logic [15:0] cal_status = 16'h0C3A;
    logic [15:0] info_word = 16'h7E81;
    bcd_pkg::bcd_cmd_t cmd;
    bcd_pkg::bcd_reply_t reply;
    bcd_pkg::bcd_op_t op;
    logic [15:0] op_data, supply_reg, reset_reg, control_reg;
    logic [1:0] input_sel;
    logic op_valid, op_done, busy, input_sel_clear, slab_power, auto_power;
    logic bunch_counter_clear, asic_config_clear, board_logic_clear, slab_clear;
    int n_errors = 0;
    int checks_done = 0;

    // 125 MHz
    always #4 ref_clk = ~ref_clk;

    bcd_decoder i_bcd_decoder (
        .ref_clk(ref_clk), .resetn(resetn), .cmd(cmd), .fast_bunch_clear(fast_bunch_clear),
        .emergency(emergency), .op_done(op_done), .status1(status1), .status2(status2),
        .cal_status(cal_status), .info_word(info_word), .reply(reply), .op(op),
        .op_data(op_data), .op_valid(op_valid), .busy(busy), .supply_reg(supply_reg),
        .reset_reg(reset_reg), .control_reg(control_reg), .input_sel(input_sel),
        .input_sel_clear(input_sel_clear), .slab_power(slab_power), .auto_power(auto_power),
        .bunch_counter_clear(bunch_counter_clear), .asic_config_clear(asic_config_clear),
        .board_logic_clear(board_logic_clear), .slab_clear(slab_clear));

    bcd_agg_model #(.DLY(20)) i_bcd_agg_model (
        .ref_clk(ref_clk), .resetn(resetn), .busy(busy), .stall(stall), .cmd(cmd),
        .op_done(op_done));

    task automatic finish_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Outputs that stand one cycle are looked at just after the taking edge
    task automatic send(input logic [15:0] c, input logic [15:0] d);
        i_bcd_agg_model.send(c, d);
        #1;
    endtask

    task automatic rd(input logic [15:0] c, input logic [15:0] d, input logic [15:0] e);
        send(c, d);
        chk({15'h0000, reply.valid}, 16'h0001, "reply valid");
        chk(reply.code, c, "reply code");
        chk(reply.data, e, "reply data");
    endtask

    // Bounded wait, a missing completion shows up as a busy mismatch afterwards
    task automatic idle_wait();
        for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
            @(posedge ref_clk);
        end
        #1;
    endtask

    function automatic logic line_of(input int b);
        case (b)
            0, 2: return board_logic_clear;
            1: return slab_clear;
            3: return asic_config_clear;
            default: return bunch_counter_clear;
        endcase
    endfunction

    task automatic t_supply();
        chk(supply_reg | reset_reg | control_reg, 16'h0000, "reset values");
        send(bcd_pkg::CMD_SUPPLY, 16'h0002);
        chk(supply_reg, 16'h0000, "auto without power");
        send(bcd_pkg::CMD_SUPPLY, 16'h0001);
        chk({15'h0000, slab_power}, 16'h0001, "power on");
        send(bcd_pkg::CMD_SUPPLY, 16'h0002);
        chk({15'h0000, auto_power}, 16'h0001, "auto on");
        rd(bcd_pkg::CMD_SUPPLY, 16'h1000, 16'h0003);
        send(bcd_pkg::CMD_SUPPLY, 16'h0000);
        chk(supply_reg, 16'h0000, "off clears auto");
    endtask

    task automatic t_pulses();
        int n;
        int m;
        logic [15:0] e;
        for (int b = 0; b < 5; b++) begin
            n = 0;
            m = 0;
            e = (b < 4) ? 16'h0006 : 16'h0004;
            if (b < 4) begin
                send(bcd_pkg::CMD_RESET, 16'h0001 << b);
            end else begin
                @(posedge ref_clk);
                fast_bunch_clear <= 1'b1;
                @(posedge ref_clk);
                fast_bunch_clear <= 1'b0;
            end
            repeat (14) begin
                @(posedge ref_clk);
                #1;
                n += int'(line_of(b));
                m += int'(reset_reg[b]);
            end
            chk(16'(n), e, "clear width");
            chk(16'(m), e, "reset bit width");
        end
    endtask

    task automatic t_reads();
        send(bcd_pkg::CMD_SET_CTRL, 16'hA5C3);
        chk(control_reg, 16'hA5C3, "control write");
        chk({15'h0000, busy}, 16'h0000, "control stays idle");
        rd(bcd_pkg::CMD_READ_STAT, 16'h0001, 16'hA5C3);
        rd(bcd_pkg::CMD_READ_STAT, 16'h0002, status1);
        rd(bcd_pkg::CMD_READ_STAT, 16'h0003, status2);
        for (int i = 0; i < 7; i++) begin
            rd(bcd_pkg::CMD_INFO, 16'h0001 << i, info_word);
        end
        rd(bcd_pkg::CMD_CAL_STAT, 16'h1000, cal_status);
        chk({15'h0000, busy}, 16'h0000, "cal status idle");
    endtask

    task automatic t_ops();
        logic [15:0] c [16] = '{16'h000C, 16'h000C, 16'h000E, 16'h0018, 16'h0070, 16'h0070,
            16'h0070, 16'h0070, 16'h0074, 16'h0076, 16'h0078, 16'h0030, 16'h004F, 16'h0050,
            16'h006F, 16'h008F};
        logic [15:0] d [16] = '{16'h0001, 16'h0080, 16'h0000, 16'h1234, 16'h0001, 16'h0002,
            16'h0003, 16'h0004, 16'h0055, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
            16'h0000, 16'h0000};
        int z [16] = '{1, 1, 1, 0, 1, 1, 1, 1, 0, 0, 1, 0, 0, 0, 0, 0};
        bcd_pkg::bcd_op_t o [16] = '{bcd_pkg::BCD_OP_LOAD_SET, bcd_pkg::BCD_OP_READ_SETS,
            bcd_pkg::BCD_OP_RESULTS, bcd_pkg::BCD_OP_FW_WORD, bcd_pkg::BCD_OP_SENSOR,
            bcd_pkg::BCD_OP_SENSOR, bcd_pkg::BCD_OP_SENSOR, bcd_pkg::BCD_OP_SENSOR,
            bcd_pkg::BCD_OP_CAL_LOAD, bcd_pkg::BCD_OP_CAL_READ, bcd_pkg::BCD_OP_PROBE,
            bcd_pkg::BCD_OP_VARIANT, bcd_pkg::BCD_OP_VARIANT, bcd_pkg::BCD_OP_VARIANT,
            bcd_pkg::BCD_OP_VARIANT, bcd_pkg::BCD_OP_VARIANT};
        for (int i = 0; i < 16; i++) begin
            send(c[i], d[i]);
            chk({12'h000, op}, {12'h000, o[i]}, "op kind");
            chk({15'h0000, op_valid}, 16'h0001, "op valid");
            chk(op_data, d[i], "op data");
            if (z[i] < 2) begin
                chk({15'h0000, busy}, 16'(z[i]), "busy state");
            end
            idle_wait();
        end
    endtask

    task automatic t_busy();
        send(bcd_pkg::CMD_RESULTS, 16'h0000);
        send(bcd_pkg::CMD_READ_STAT, 16'h0001);
        chk({15'h0000, reply.valid}, 16'h0000, "read while busy");
        send(bcd_pkg::CMD_SET_CTRL, 16'h0F0F);
        chk(control_reg, 16'hA5C3, "write while busy");
        idle_wait();
        chk({15'h0000, busy}, 16'h0000, "back to idle");
        rd(bcd_pkg::CMD_READ_STAT, 16'h0001, 16'hA5C3);
        stall <= 1'b1;
        send(bcd_pkg::CMD_PROBE, 16'h0001);
        @(posedge ref_clk);
        emergency <= 1'b1;
        @(posedge ref_clk);
        emergency <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({15'h0000, busy}, 16'h0000, "emergency abort");
        send(bcd_pkg::CMD_PROBE, 16'h0001);
        send(bcd_pkg::CMD_RESET, 16'h0001);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({15'h0000, busy}, 16'h0000, "reset abort");
        stall <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic t_select();
        send(bcd_pkg::CMD_SEL_INPUT, 16'h0001);
        chk({14'h0000, input_sel}, 16'h0001, "board link");
        rd(bcd_pkg::CMD_SEL_INPUT, 16'h1000, 16'h0001);
        send(bcd_pkg::CMD_SEL_INPUT, 16'h0000);
        chk({14'h0000, input_sel}, 16'h0000, "aggregator link");
        send(bcd_pkg::CMD_SEL_INPUT, 16'h0002);
        chk({15'h0000, input_sel_clear}, 16'h0001, "selection reset");
    endtask

    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        t_supply();
        t_pulses();
        t_reads();
        t_ops();
        t_busy();
        t_select();
        finish_test();
    end
endmodule // tb_top
